// [rts_map.svh]
// register offsets, field positions, reset values and timing counts of the rt status block
`ifndef RTS_MAP_SVH
`define RTS_MAP_SVH

// ==========================================================
// host register offsets
`define RTS_ADDR_W 5
`define RTS_OFF_STATUS 5'h07
`define RTS_OFF_TICK 5'h08
`define RTS_OFF_ILOG 5'h09
`define RTS_OFF_MIWA 5'h0a

// ==========================================================
// status word flag register fields
`define RTS_STAT_TF 0
`define RTS_STAT_UNUSED 1
`define RTS_STAT_SSF 2
`define RTS_STAT_BUSY 3
`define RTS_STAT_SVCREQ 8
`define RTS_STAT_INST 9
`define RTS_STAT_TXCLR 15
`define RTS_STAT_WMASK 16'h830d
`define RTS_STAT_RESET 16'h0000

// ==========================================================
// interrupt log pointer and count
`define RTS_ILOG_RESET 16'h0040
`define RTS_ILOG_BASE 8'h40
`define RTS_ILOG_LAST 8'h5e
`define RTS_ILOG_STEP 8'h02
`define RTS_ILOG_CNT_MAX 8'hff
`define RTS_ILOG_HW_SRC 16'h0000

// ==========================================================
// tick rate selection and timing
`define RTS_TSEL_EXT 3'h6
`define RTS_TSEL_OFF 3'h7
`define RTS_TICK_BASE_US 2
`define RTS_CLK_MHZ 100
`define RTS_MIW_DELAY_US 5
`define RTS_MIW_DELAY_CYC (`RTS_MIW_DELAY_US * `RTS_CLK_MHZ)
`define RTS_MIWA_RESET 16'h0000
`define RTS_TICK_RESET 16'h0000

`endif

// [rts_pkg.sv]
// types shared by the rt status block
package rts_pkg;
    typedef logic [15:0] rts_word_type;
    typedef enum logic [0:0] {LOG_IDLE, LOG_SRC} rts_log_state_type;
endpackage

// [rts_tick_gen.sv]
// time-tag tick generator: programmable internal period or synchronised external clock
`include "rts_map.svh"
module rts_tick_gen import rts_pkg::*; #(
    parameter int CYC_PER_US = `RTS_CLK_MHZ
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic restart,
    input wire logic [2:0] tick_rate_select,
    input wire logic ext_tick_pin,
    output logic tick
);
    logic [15:0] div_reg, div_next;
    logic [2:0] ext_reg, ext_next;
    logic tick_reg, tick_next;

    // cycles per tick minus one: 2, 4, ... 64 us
    function automatic logic [15:0] period_last(input logic [2:0] sel);
        period_last = 16'(((`RTS_TICK_BASE_US << sel) * CYC_PER_US) - 1);
    endfunction

    always_comb begin
        ext_next = {ext_reg[1:0], ext_tick_pin};
        div_next = div_reg + 16'h0001;
        tick_next = 1'b0;
        if (restart || tick_rate_select >= `RTS_TSEL_EXT) begin
            div_next = 16'h0000;
        end else if (div_reg >= period_last(tick_rate_select)) begin
            div_next = 16'h0000;
            tick_next = 1'b1;
        end
        // edge seen only on the second and third stage, never the first
        if (tick_rate_select == `RTS_TSEL_EXT) begin
            tick_next = ext_reg[1] && !ext_reg[2];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_reg <= 16'h0000;
            ext_reg <= 3'h0;
            tick_reg <= 1'b0;
        end else begin
            div_reg <= div_next;
            ext_reg <= ext_next;
            tick_reg <= tick_next;
        end
    end

    assign tick = tick_reg;
endmodule

// [rts_status_regs.sv]
// rt status registers: status flags, time-tag counter, interrupt log pointer, miw address
// ==========================================================
// Overview of operation
// - subsystem status set by register or pin
// - vector mode command clears subsystem bit unless clear option set
// - bit 0 write sets terminal flag
// - bit 1 unused, reads zero
// - both resets clear subsystem and terminal bits
// - time-tag read only, free running, resets clear
// - tick period 2 to 64 us or external
// - sync without data zeroes time-tag
// - host clear bit zeroes time-tag
// - options 11 load sync data always
// - load done before status transmission
// - options 00 no load, status still sent
// - options 01/10 load on data bit 0
// - log register reads 0x0040 after master reset
// - pointer bits even, 0x40 to 0x5e
// - count saturates 255, cleared by host read
// - sixteen entries, two words each, ring
// - source word descriptor address or zero
// - pointer wraps after 0x5e to 0x40
// - miw address cleared only by master reset
// - miw address updates 500 cycles after active, 5 us at 100 MHz
// - flags persist unless transmit once set
`include "rts_map.svh"
module rts_status_regs import rts_pkg::*; #(
    parameter int CYC_PER_US = `RTS_CLK_MHZ
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic soft_reset,
    input wire logic host_cs,
    input wire logic host_wr,
    input wire logic host_rd,
    input wire logic [`RTS_ADDR_W-1:0] host_addr,
    input wire logic [15:0] host_wdata,
    output logic [15:0] host_rdata,
    input wire logic subsystem_flag_pin,
    input wire logic vector_clear_option,
    input wire logic sync_load_option_lo,
    input wire logic sync_load_option_hi,
    input wire logic [2:0] tick_rate_select,
    input wire logic tick_count_clear,
    input wire logic ext_tick_pin,
    input wire logic transmit_vector_mode_cmd,
    input wire logic sync_no_data_mode_cmd,
    input wire logic sync_with_data_mode_cmd,
    input wire logic [15:0] sync_data_word,
    input wire logic status_sent,
    input wire logic irq_event,
    input wire logic irq_from_msg,
    input wire logic [15:0] irq_ident_word,
    input wire logic [15:0] irq_ctrl_addr,
    output logic irq_log_ready,
    output logic log_wr_en,
    output logic [7:0] log_wr_addr,
    output logic [15:0] log_wr_data,
    input wire logic active_rise,
    input wire logic [15:0] msg_info_addr,
    output logic [15:0] status_flags_out
);
    localparam logic [9:0] MIW_DELAY = 10'(`RTS_MIW_DELAY_CYC);

    // ==========================================================
    // decode and pin synchroniser
    function automatic logic hit(input logic [`RTS_ADDR_W-1:0] a, input logic [`RTS_ADDR_W-1:0] off);
        hit = host_cs && (a == off);
    endfunction

    function automatic logic sync_load_ok(input logic hi, input logic lo, input logic d0);
        case ({hi, lo})
            2'b11: sync_load_ok = 1'b1;
            2'b01: sync_load_ok = !d0;
            2'b10: sync_load_ok = d0;
            default: sync_load_ok = 1'b0;
        endcase
    endfunction

    logic wr_stat, rd_ilog;
    logic [1:0] ssf_sync_reg, ssf_sync_next;
    logic tick;

    assign wr_stat = host_wr && hit(host_addr, `RTS_OFF_STATUS);
    assign rd_ilog = host_rd && hit(host_addr, `RTS_OFF_ILOG);
    assign ssf_sync_next = {ssf_sync_reg[0], subsystem_flag_pin};

    // ==========================================================
    // status word flag register
    rts_word_type stat_reg, stat_next, flags_reg, flags_next;

    always_comb begin
        stat_next = stat_reg;
        // one-shot flags drop after they have gone out once
        if (status_sent && stat_reg[`RTS_STAT_TXCLR]) begin
            stat_next = `RTS_STAT_RESET;
        end
        if (transmit_vector_mode_cmd && !vector_clear_option) begin
            stat_next[`RTS_STAT_SSF] = 1'b0;
        end
        if (wr_stat) begin
            stat_next = host_wdata & `RTS_STAT_WMASK;
        end
        if (soft_reset) begin
            stat_next = `RTS_STAT_RESET;
        end
        flags_next = stat_next;
        flags_next[`RTS_STAT_SSF] = stat_next[`RTS_STAT_SSF] | ssf_sync_reg[1];
        flags_next[`RTS_STAT_TXCLR] = 1'b0;
    end

    // ==========================================================
    // time-tag counter
    rts_word_type tt_reg, tt_next;
    logic sync_load;

    assign sync_load = sync_with_data_mode_cmd
        && sync_load_ok(sync_load_option_hi, sync_load_option_lo, sync_data_word[0]);

    rts_tick_gen #(
        .CYC_PER_US(CYC_PER_US)
    ) u_tick (
        .clk(clk),
        .rst_n(rst_n),
        .restart(soft_reset),
        .tick_rate_select(tick_rate_select),
        .ext_tick_pin(ext_tick_pin),
        .tick(tick)
    );

    always_comb begin
        tt_next = tt_reg;
        if (tick) begin
            tt_next = tt_reg + 16'h0001;
        end
        // options 00: the engine still answers, the host does the sync work
        if (sync_load) begin
            tt_next = sync_data_word;
        end
        if (sync_no_data_mode_cmd) begin
            tt_next = `RTS_TICK_RESET;
        end
        if (tick_count_clear || soft_reset) begin
            tt_next = `RTS_TICK_RESET;
        end
    end

    // ==========================================================
    // interrupt log pointer, count and ring writes
    rts_log_state_type log_state_reg, log_state_next;
    logic [7:0] ptr_reg, ptr_next, cnt_reg, cnt_next;
    rts_word_type src_reg, src_next;
    logic lwe_next;
    logic [7:0] lwa_next;
    rts_word_type lwd_next;
    logic log_take;

    assign log_take = irq_event && (log_state_reg == LOG_IDLE);

    always_comb begin
        log_state_next = log_state_reg;
        ptr_next = ptr_reg;
        src_next = src_reg;
        lwe_next = 1'b0;
        lwa_next = log_wr_addr;
        lwd_next = log_wr_data;
        // a read clears the count, but a logged event in the same cycle still counts
        cnt_next = rd_ilog ? 8'h00 : cnt_reg;
        if (log_take && cnt_next != `RTS_ILOG_CNT_MAX) begin
            cnt_next = cnt_next + 8'h01;
        end
        case (log_state_reg)
            LOG_IDLE: begin
                if (irq_event) begin
                    lwe_next = 1'b1;
                    lwa_next = ptr_reg;
                    lwd_next = irq_ident_word;
                    src_next = irq_from_msg ? irq_ctrl_addr : `RTS_ILOG_HW_SRC;
                    log_state_next = LOG_SRC;
                end
            end
            LOG_SRC: begin
                lwe_next = 1'b1;
                lwa_next = ptr_reg | 8'h01;
                lwd_next = src_reg;
                ptr_next = (ptr_reg == `RTS_ILOG_LAST) ? `RTS_ILOG_BASE
                                                       : ptr_reg + `RTS_ILOG_STEP;
                log_state_next = LOG_IDLE;
            end
            default: begin
                log_state_next = LOG_IDLE;
            end
        endcase
    end

    // ==========================================================
    // current message information word address
    rts_word_type miwa_reg, miwa_next;
    logic [9:0] miw_cnt_reg, miw_cnt_next;

    always_comb begin
        miwa_next = miwa_reg;
        miw_cnt_next = miw_cnt_reg;
        if (active_rise) begin
            miw_cnt_next = MIW_DELAY;
        end else if (miw_cnt_reg != 10'h000) begin
            miw_cnt_next = miw_cnt_reg - 10'h001;
            if (miw_cnt_reg == 10'h001) begin
                miwa_next = msg_info_addr;
            end
        end
    end

    // ==========================================================
    // host read data
    rts_word_type rdata_next;

    always_comb begin
        rdata_next = host_rdata;
        if (host_rd && host_cs) begin
            case (host_addr)
                `RTS_OFF_STATUS: rdata_next = stat_reg;
                `RTS_OFF_TICK: rdata_next = tt_reg;
                `RTS_OFF_ILOG: rdata_next = {cnt_reg, ptr_reg};
                `RTS_OFF_MIWA: rdata_next = miwa_reg;
                default: rdata_next = 16'h0000;
            endcase
        end
    end

    // ==========================================================
    // registers: master reset only, soft reset acts through the next values
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ssf_sync_reg <= 2'h0;
            stat_reg <= `RTS_STAT_RESET;
            flags_reg <= `RTS_STAT_RESET;
            tt_reg <= `RTS_TICK_RESET;
            log_state_reg <= LOG_IDLE;
            ptr_reg <= 8'(`RTS_ILOG_RESET);
            cnt_reg <= 8'h00;
            src_reg <= 16'h0000;
            log_wr_en <= 1'b0;
            log_wr_addr <= 8'h00;
            log_wr_data <= 16'h0000;
            miwa_reg <= `RTS_MIWA_RESET;
            miw_cnt_reg <= 10'h000;
            host_rdata <= 16'h0000;
        end else begin
            ssf_sync_reg <= ssf_sync_next;
            stat_reg <= stat_next;
            flags_reg <= flags_next;
            tt_reg <= tt_next;
            log_state_reg <= log_state_next;
            ptr_reg <= ptr_next;
            cnt_reg <= cnt_next;
            src_reg <= src_next;
            log_wr_en <= lwe_next;
            log_wr_addr <= lwa_next;
            log_wr_data <= lwd_next;
            miwa_reg <= miwa_next;
            miw_cnt_reg <= miw_cnt_next;
            host_rdata <= rdata_next;
        end
    end

    assign status_flags_out = flags_reg;
    assign irq_log_ready = (log_state_reg == LOG_IDLE);

    // ==========================================================
    // assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_ssf_out;
        ssf_sync_reg[1] |=> status_flags_out[`RTS_STAT_SSF];
    endproperty
    a_ssf_out: assert property (p_ssf_out) else $error("pin flag not in status");

    property p_vec_clear;
        transmit_vector_mode_cmd && !vector_clear_option && !wr_stat
            |=> !stat_reg[`RTS_STAT_SSF];
    endproperty
    a_vec_clear: assert property (p_vec_clear) else $error("vector cmd kept flag");

    property p_tf_write;
        wr_stat && host_wdata[0] && !soft_reset |=> stat_reg[`RTS_STAT_TF] ##0 !stat_reg[1];
    endproperty
    a_tf_write: assert property (p_tf_write) else $error("terminal flag write lost");

    property p_bit1_zero;
        host_rd && hit(host_addr, `RTS_OFF_STATUS) |=> !host_rdata[`RTS_STAT_UNUSED];
    endproperty
    a_bit1_zero: assert property (p_bit1_zero) else $error("unused bit reads one");

    property p_soft_clr;
        soft_reset |=> stat_reg == 16'h0000 && tt_reg == 16'h0000;
    endproperty
    a_soft_clr: assert property (p_soft_clr) else $error("soft reset left state");

    property p_sync0;
        sync_no_data_mode_cmd || tick_count_clear |=> tt_reg == 16'h0000;
    endproperty
    a_sync0: assert property (p_sync0) else $error("time tag not zeroed");

    property p_load;
        sync_load && !sync_no_data_mode_cmd && !tick_count_clear && !soft_reset
            |=> tt_reg == $past(sync_data_word);
    endproperty
    a_load: assert property (p_load) else $error("sync data not loaded");

    property p_ptr_range;
        !ptr_reg[0] && ptr_reg >= `RTS_ILOG_BASE && ptr_reg <= `RTS_ILOG_LAST;
    endproperty
    a_ptr_range: assert property (p_ptr_range) else $error("log pointer out of range");

    property p_cnt_sat;
        cnt_reg == 8'hff && !rd_ilog |=> cnt_reg == 8'hff;
    endproperty
    a_cnt_sat: assert property (p_cnt_sat) else $error("count left saturation");

    property p_wrap;
        log_state_reg == LOG_SRC && ptr_reg == `RTS_ILOG_LAST
            |=> ptr_reg == `RTS_ILOG_BASE && log_wr_addr == 8'h5f;
    endproperty
    a_wrap: assert property (p_wrap) else $error("log pointer did not wrap");

    property p_miw;
        active_rise ##1 (!active_rise) [*8] |-> miw_cnt_reg == 10'(MIW_DELAY - 10'd7);
    endproperty
    a_miw: assert property (p_miw) else $error("miw delay count wrong");

    c_wrap: cover property (log_state_reg == LOG_SRC && ptr_reg == `RTS_ILOG_LAST);
    c_load: cover property (sync_load);
    c_miw: cover property (miw_cnt_reg == 10'h001);
    c_txclr: cover property (status_sent && stat_reg[`RTS_STAT_TXCLR]);
endmodule

// [rts_log_ram.sv]
// log ram model standing in for the shared memory behind the interrupt log port
module rts_log_ram (
    input wire logic clk,
    input wire logic wr_en,
    input wire logic [7:0] wr_addr,
    input wire logic [15:0] wr_data
);
    timeunit 1ns;
    timeprecision 1ns;
    // cells never written stay unknown, so a missing write cannot pass a case compare
    logic [15:0] mem [0:255];
    always @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end
endmodule

// [tb_rts_status_regs.sv]
// self-checking bench of the rt status registers with the log ram model beside them
`include "rts_map.svh"
module tb_rts_status_regs import rts_pkg::*; ();
    timeunit 1ns;
    timeprecision 1ns;
    // short microsecond keeps tick periods at 2..64 cycles
    localparam int CPU = 1;
    logic clk, rst_n, soft_reset, host_cs, host_wr, host_rd;
    logic [4:0] host_addr;
    rts_word_type host_wdata, host_rdata, sync_data_word, irq_ident_word, irq_ctrl_addr;
    rts_word_type msg_info_addr, status_flags_out, log_wr_data;
    logic subsystem_flag_pin, vector_clear_option, sync_load_option_lo, sync_load_option_hi;
    logic [2:0] tick_rate_select;
    logic tick_count_clear, ext_tick_pin, transmit_vector_mode_cmd, sync_no_data_mode_cmd;
    logic sync_with_data_mode_cmd, status_sent, irq_event, irq_from_msg, irq_log_ready;
    logic log_wr_en, active_rise;
    logic [7:0] log_wr_addr, p;
    int errors = 0;
    int checks_done = 0;
    logic [31:0] seed = 32'h000096b6;

    rts_status_regs #(.CYC_PER_US(CPU)) i_dut (.clk, .rst_n, .soft_reset, .host_cs, .host_wr,
        .host_rd, .host_addr, .host_wdata, .host_rdata, .subsystem_flag_pin,
        .vector_clear_option, .sync_load_option_lo, .sync_load_option_hi, .tick_rate_select,
        .tick_count_clear, .ext_tick_pin, .transmit_vector_mode_cmd, .sync_no_data_mode_cmd,
        .sync_with_data_mode_cmd, .sync_data_word, .status_sent, .irq_event, .irq_from_msg,
        .irq_ident_word, .irq_ctrl_addr, .irq_log_ready, .log_wr_en, .log_wr_addr,
        .log_wr_data, .active_rise, .msg_info_addr, .status_flags_out);
    rts_log_ram i_ram (.clk(clk), .wr_en(log_wr_en), .wr_addr(log_wr_addr), .wr_data(log_wr_data));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ==========================================================
    // helpers
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic loads(logic [1:0] opt, rts_word_type d);
        return opt == 2'h3 || (opt == 2'h1 && !d[0]) || (opt == 2'h2 && d[0]);
    endfunction
    task automatic chk(string what, rts_word_type exp, rts_word_type got);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_near(string what, int exp, rts_word_type got, int tol);
        checks_done++;
        if ($isunknown(got) || int'(got) < exp - tol || int'(got) > exp + tol) begin
            errors++;
            $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
        end
    endtask
    task automatic cyc(int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wr_reg(logic [4:0] a, rts_word_type d);
        @(posedge clk);
        {host_cs, host_wr, host_addr, host_wdata} <= {2'h3, a, d};
        @(posedge clk);
        {host_cs, host_wr} <= 2'h0;
        #1;
    endtask
    task automatic rd_reg(logic [4:0] a, output rts_word_type d);
        @(posedge clk);
        {host_cs, host_rd, host_addr} <= {2'h3, a};
        @(posedge clk);
        {host_cs, host_rd} <= 2'h0;
        #1;
        d = host_rdata;
    endtask
    // one-cycle pulse on a command input picked by code
    task automatic mc(int k);
        @(posedge clk);
        case (k)
            0: transmit_vector_mode_cmd <= 1'b1;
            1: sync_no_data_mode_cmd <= 1'b1;
            2: sync_with_data_mode_cmd <= 1'b1;
            3: status_sent <= 1'b1;
            4: active_rise <= 1'b1;
            5: tick_count_clear <= 1'b1;
            default: soft_reset <= 1'b1;
        endcase
        @(posedge clk);
        {transmit_vector_mode_cmd, sync_no_data_mode_cmd, sync_with_data_mode_cmd} <= 3'h0;
        {status_sent, active_rise, tick_count_clear, soft_reset} <= 4'h0;
        #1;
    endtask
    task automatic sync_load(logic [1:0] opt, rts_word_type d);
        @(posedge clk);
        {sync_load_option_hi, sync_load_option_lo} <= opt;
        sync_data_word <= d;
        mc(2);
    endtask
    task automatic irq(rts_word_type id, rts_word_type ca, logic msg, logic hold);
        @(posedge clk);
        {irq_event, irq_from_msg, irq_ident_word, irq_ctrl_addr} <= {1'b1, msg, id, ca};
        @(posedge clk);
        // with hold set, a second request cycle lands while the log is busy and must be dropped
        irq_event <= hold;
        @(negedge clk);
        chk("log ready", 16'h0000, {15'h0000, irq_log_ready});
        @(posedge clk);
        irq_event <= 1'b0;
        cyc(2);
        #1;
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ==========================================================
    // main sequence
    initial begin
        rts_word_type d, v, ms;
        logic [31:0] r;
        {rst_n, soft_reset, host_cs, host_wr, host_rd, host_addr, host_wdata} = '0;
        {subsystem_flag_pin, vector_clear_option, sync_load_option_lo} = '0;
        {sync_load_option_hi, tick_count_clear, ext_tick_pin, sync_data_word} = '0;
        {transmit_vector_mode_cmd, sync_no_data_mode_cmd, sync_with_data_mode_cmd} = '0;
        {status_sent, irq_event, irq_from_msg, irq_ident_word, irq_ctrl_addr} = '0;
        {active_rise, msg_info_addr} = '0;
        tick_rate_select = 3'h7;
        cyc(8);
        rst_n <= 1'b1;
        rd_reg(`RTS_OFF_STATUS, d);
        chk("status reset", 16'h0000, d);
        wr_reg(`RTS_OFF_TICK, 16'hffff);
        rd_reg(`RTS_OFF_TICK, d);
        chk("tick reset and read only", 16'h0000, d);
        rd_reg(`RTS_OFF_ILOG, d);
        chk("log reset", `RTS_ILOG_RESET, d);
        rd_reg(`RTS_OFF_MIWA, d);
        chk("miw reset", 16'h0000, d);
        rd_reg(5'h1f, d);
        chk("unmapped read", 16'h0000, d);
        $display("test reset done");
        wr_reg(`RTS_OFF_STATUS, 16'hffff);
        rd_reg(`RTS_OFF_STATUS, d);
        chk("status mask", `RTS_STAT_WMASK, d);
        chk("terminal flag out", 16'h0001, status_flags_out & 16'h0001);
        wr_reg(`RTS_OFF_STATUS, 16'h0000);
        subsystem_flag_pin <= 1'b1;
        cyc(5);
        chk("subsystem from pin", 16'h0004, status_flags_out & 16'h0004);
        subsystem_flag_pin <= 1'b0;
        for (int i = 0; i < 2; i++) begin
            vector_clear_option <= i[0];
            wr_reg(`RTS_OFF_STATUS, 16'h0004);
            chk("subsystem from reg", 16'h0004, status_flags_out & 16'h0004);
            mc(0);
            rd_reg(`RTS_OFF_STATUS, d);
            chk("vector clear", i[0] ? 16'h0004 : 16'h0000, d);
        end
        wr_reg(`RTS_OFF_STATUS, 16'h8001);
        mc(3);
        rd_reg(`RTS_OFF_STATUS, d);
        chk("transmit once", 16'h0000, d);
        wr_reg(`RTS_OFF_STATUS, 16'h0001);
        mc(3);
        rd_reg(`RTS_OFF_STATUS, d);
        chk("flag persists", 16'h0001, d);
        $display("test status done");
        for (int i = 0; i < 8; i++) begin
            r = rnd();
            v = r[31:16] | 16'h0100;
            d = {r[15:1], i[2]};
            sync_load(2'h3, v);
            sync_load(i[1:0], d);
            rd_reg(`RTS_OFF_TICK, ms);
            chk("sync load", loads(i[1:0], d) ? d : v, ms);
            mc(i[0] ? 5 : 1);
            rd_reg(`RTS_OFF_TICK, ms);
            chk("tick zeroed", 16'h0000, ms);
        end
        sync_load(2'h3, 16'hffff);
        tick_rate_select <= 3'h0;
        cyc(6);
        rd_reg(`RTS_OFF_TICK, d);
        chk_near("tick wrap", 4, d, 2);
        for (int s = 0; s < 6; s++) begin
            tick_rate_select <= s[2:0];
            mc(5);
            cyc(128);
            rd_reg(`RTS_OFF_TICK, d);
            chk_near("tick rate", 130 / (2 << s), d, 2);
        end
        tick_rate_select <= `RTS_TSEL_EXT;
        mc(5);
        repeat (5) begin
            ext_tick_pin <= 1'b1;
            cyc(4);
            ext_tick_pin <= 1'b0;
            cyc(4);
        end
        cyc(6);
        rd_reg(`RTS_OFF_TICK, d);
        chk("external ticks", 16'h0005, d);
        tick_rate_select <= `RTS_TSEL_OFF;
        $display("test time tag done");
        p = `RTS_ILOG_BASE;
        for (int i = 0; i < 277; i++) begin
            r = rnd();
            irq(r[15:0], r[31:16], r[0], r[1]);
            chk("log ident", r[15:0], i_ram.mem[p]);
            chk("log source", r[0] ? r[31:16] : `RTS_ILOG_HW_SRC, i_ram.mem[p + 1]);
            p = (p == `RTS_ILOG_LAST) ? `RTS_ILOG_BASE : p + `RTS_ILOG_STEP;
            if (i == 16) begin
                rd_reg(`RTS_OFF_ILOG, d);
                chk("log after 17", {8'h11, p}, d);
            end
        end
        rd_reg(`RTS_OFF_ILOG, d);
        chk("log count saturates", {8'hff, p}, d);
        rd_reg(`RTS_OFF_ILOG, d);
        chk("log count cleared", {8'h00, p}, d);
        $display("test interrupt log done");
        r = rnd();
        msg_info_addr <= r[15:0];
        mc(4);
        rd_reg(`RTS_OFF_MIWA, d);
        chk("miw early", 16'h0000, d);
        cyc(600);
        rd_reg(`RTS_OFF_MIWA, d);
        chk("miw late", r[15:0], d);
        $display("test miw done");
        wr_reg(`RTS_OFF_STATUS, 16'h0005);
        sync_load(2'h3, 16'h1234);
        mc(6);
        rd_reg(`RTS_OFF_STATUS, d);
        chk("soft status", 16'h0000, d);
        rd_reg(`RTS_OFF_TICK, d);
        chk("soft tick", 16'h0000, d);
        rd_reg(`RTS_OFF_ILOG, d);
        chk("soft log kept", {8'h00, p}, d);
        rd_reg(`RTS_OFF_MIWA, d);
        chk("soft miw kept", r[15:0], d);
        $display("test soft reset done");
        rst_n <= 1'b0;
        cyc(2);
        rst_n <= 1'b1;
        rd_reg(`RTS_OFF_ILOG, d);
        chk("master log", `RTS_ILOG_RESET, d);
        rd_reg(`RTS_OFF_MIWA, d);
        chk("master miw", 16'h0000, d);
        $display("test master reset done");
        close_out();
    end

    // sized well above the roughly 3000 cycles the tests need
    initial begin
        #400000;
        errors++;
        $display("watchdog expired");
        close_out();
    end
endmodule
